/* ifed_consts.svh */
// Address map, field positions and reset values of the interrupt flag/enable block
`ifndef IFED_CONSTS_SVH
`define IFED_CONSTS_SVH

// Register addresses on the processor bus
`define IFED_ADDR_CLR_ALIAS 16'h0010
`define IFED_ADDR_FLAGS 16'h0011
`define IFED_ADDR_ENABLES 16'h0012
`define IFED_ADDR_CNTA_LOW 16'h0018
`define IFED_ADDR_CNTA_CLR 16'h001a
`define IFED_ADDR_CNTB_LOW 16'h001c
`define IFED_ADDR_CNTB_CLR 16'h001e

// Read values
`define IFED_ALIAS_RD_VAL 8'hff
`define IFED_UNMAPPED_RD_VAL 8'h00

// Reset values
`define IFED_FLAGS_RST 8'h00
`define IFED_ENABLES_RST 8'h00

// Flag bit positions
`define IFED_BIT_RISE_A 0
`define IFED_BIT_RISE_B 1
`define IFED_BIT_FALL_A 2
`define IFED_BIT_FALL_B 3
`define IFED_BIT_CNTA 4
`define IFED_BIT_CNTB 5
`define IFED_BIT_RX 6
`define IFED_BIT_TX 7

// Serial status field positions
`define IFED_SS_RX_LO 0
`define IFED_SS_RX_HI 3
`define IFED_SS_TX_IDLE 5
`define IFED_SS_TX_EMPTY 6
`define IFED_SS_TX_DONE 7

`endif

/* ifed_pkg.sv */
// Types shared by the interrupt flag/enable block
package ifed_pkg;
	typedef logic [7:0] ifed_byte_t;
	typedef logic [15:0] ifed_addr_t;
	typedef logic [3:0] ifed_edge_t;
endpackage : ifed_pkg

/* ifed_edge_det.sv */
// Pin synchroniser and single edge detector
`timescale 1ns/1ps
module ifed_edge_det #(
	parameter bit RISING = 1'b1
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Pin and detected edge
	input wire logic pin_i,
	output logic edge_o
);
	// Reset to the level that cannot fake an edge
	localparam logic IDLE = RISING;

	logic meta_reg, meta_next;
	logic sync_reg, sync_next;
	logic prev_reg, prev_next;
	logic edge_reg, edge_next;

	// Two-stage sync, history and edge compare
	always_comb begin
		meta_next = pin_i;
		sync_next = meta_reg;
		prev_next = sync_reg;
		if (RISING) begin
			edge_next = sync_reg & ~prev_reg;
		end else begin
			edge_next = ~sync_reg & prev_reg;
		end
	end

	// Registers
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_reg <= IDLE;
			sync_reg <= IDLE;
			prev_reg <= IDLE;
			edge_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
			edge_reg <= edge_next;
		end
	end

	assign edge_o = edge_reg;
endmodule : ifed_edge_det

/* ifed_flag_bit.sv */
// Sticky flag bit where a set outranks a clear
`timescale 1ns/1ps
module ifed_flag_bit (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Set and clear strobes
	input wire logic set_i,
	input wire logic clr_i,
	// Flag state
	output logic flag_o
);
	logic flag_reg, flag_next;

	// Set wins over clear in the same cycle
	always_comb begin
		flag_next = set_i | (flag_reg & ~clr_i);
	end

	// Register
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_o = flag_reg;
endmodule : ifed_flag_bit

/* ifed_irq_ctrl.sv */
// Interrupt flag and enable registers with request merge
`timescale 1ns/1ps
`include "ifed_consts.svh"

module ifed_irq_ctrl
	import ifed_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Processor register bus
	input wire ifed_addr_t cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire ifed_byte_t cpu_wdata_i,
	output ifed_byte_t cpu_rdata_o,
	output logic cpu_rsel_o,
	// Edge-detect pins
	input wire logic edge_pin_rise_a_i,
	input wire logic edge_pin_rise_b_i,
	input wire logic edge_pin_fall_a_i,
	input wire logic edge_pin_fall_b_i,
	// Counter and serial events
	input wire logic cnt_a_underflow_i,
	input wire logic cnt_b_underflow_i,
	input wire ifed_byte_t serial_status_reg_i,
	// Interrupt request to the core
	output logic irq_req_n_o
);
	// Address match helper
	function automatic logic hit(input ifed_addr_t a, input ifed_addr_t ref_a);
		hit = (a == ref_a);
	endfunction : hit

	ifed_edge_t edge_set;
	ifed_edge_t edge_clr;
	logic [5:0] sticky;
	logic [5:0] sticky_set;
	logic [5:0] sticky_clr;
	ifed_byte_t pending_flag_reg;
	ifed_byte_t mask_enable_reg, mask_enable_next;
	logic rx_flag_reg, rx_flag_next;
	logic tx_flag_reg, tx_flag_next;
	ifed_byte_t rdata_reg, rdata_next;
	logic rsel_reg, rsel_next;
	logic irq_n_reg, irq_n_next;
	logic wr_flags;
	logic wr_alias;

	// Edge detectors on the four pins, independent of port use
	ifed_edge_det #(.RISING(1'b1)) u_rise_a (
		.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.pin_i(edge_pin_rise_a_i), .edge_o(edge_set[0]));
	ifed_edge_det #(.RISING(1'b1)) u_rise_b (
		.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.pin_i(edge_pin_rise_b_i), .edge_o(edge_set[1]));
	ifed_edge_det #(.RISING(1'b0)) u_fall_a (
		.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.pin_i(edge_pin_fall_a_i), .edge_o(edge_set[2]));
	ifed_edge_det #(.RISING(1'b0)) u_fall_b (
		.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.pin_i(edge_pin_fall_b_i), .edge_o(edge_set[3]));

	// Write decode for the flag register and its alias
	assign wr_flags = cpu_wr_i & hit(cpu_addr_i, `IFED_ADDR_FLAGS);
	assign wr_alias = cpu_wr_i & hit(cpu_addr_i, `IFED_ADDR_CLR_ALIAS);

	// Zero bits of the write-back clear edge flags; ones ignored
	assign edge_clr = (wr_flags | wr_alias) ? ~cpu_wdata_i[3:0] : 4'h0;

	// Set and clear strobes of the six sticky flags
	assign sticky_set = {cnt_b_underflow_i, cnt_a_underflow_i, edge_set};
	assign sticky_clr[3:0] = edge_clr;
	assign sticky_clr[4] = (cpu_rd_i & hit(cpu_addr_i, `IFED_ADDR_CNTA_LOW))
		| (cpu_wr_i & hit(cpu_addr_i, `IFED_ADDR_CNTA_CLR));
	assign sticky_clr[5] = (cpu_rd_i & hit(cpu_addr_i, `IFED_ADDR_CNTB_LOW))
		| (cpu_wr_i & hit(cpu_addr_i, `IFED_ADDR_CNTB_CLR));

	// Sticky flag cells
	for (genvar i = 0; i < 6; i++) begin : g_flag
		ifed_flag_bit u_flag (
			.ref_clk_i(ref_clk_i),
			.arst_n_i(arst_n_i),
			.set_i(sticky_set[i]),
			.clr_i(sticky_clr[i]),
			.flag_o(sticky[i])
		);
	end

	// Pending flag vector
	assign pending_flag_reg = {tx_flag_reg, rx_flag_reg, sticky};

	// Serial flags follow the status bits
	always_comb begin
		rx_flag_next = |serial_status_reg_i[`IFED_SS_RX_HI:`IFED_SS_RX_LO];
		tx_flag_next = (serial_status_reg_i[`IFED_SS_TX_EMPTY] & ~serial_status_reg_i[`IFED_SS_TX_IDLE])
			| serial_status_reg_i[`IFED_SS_TX_DONE];
	end

	// Enable register: full byte load
	always_comb begin
		mask_enable_next = mask_enable_reg;
		if (cpu_wr_i && hit(cpu_addr_i, `IFED_ADDR_ENABLES)) begin
			mask_enable_next = cpu_wdata_i;
		end
	end

	// Read data, registered one cycle after the strobe
	always_comb begin
		rdata_next = `IFED_UNMAPPED_RD_VAL;
		rsel_next = 1'b0;
		if (cpu_rd_i) begin
			if (hit(cpu_addr_i, `IFED_ADDR_FLAGS)) begin
				rdata_next = pending_flag_reg;
				rsel_next = 1'b1;
			end else if (hit(cpu_addr_i, `IFED_ADDR_CLR_ALIAS)) begin
				rdata_next = `IFED_ALIAS_RD_VAL;
				rsel_next = 1'b1;
			end else if (hit(cpu_addr_i, `IFED_ADDR_ENABLES)) begin
				rdata_next = mask_enable_reg;
				rsel_next = 1'b1;
			end
		end
	end

	// Merged request, active low
	always_comb begin
		irq_n_next = ~|(pending_flag_reg & mask_enable_reg);
	end

	// Registers
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mask_enable_reg <= `IFED_ENABLES_RST;
			rx_flag_reg <= 1'b0;
			tx_flag_reg <= 1'b0;
			rdata_reg <= `IFED_UNMAPPED_RD_VAL;
			rsel_reg <= 1'b0;
			irq_n_reg <= 1'b1;
		end else begin
			mask_enable_reg <= mask_enable_next;
			rx_flag_reg <= rx_flag_next;
			tx_flag_reg <= tx_flag_next;
			rdata_reg <= rdata_next;
			rsel_reg <= rsel_next;
			irq_n_reg <= irq_n_next;
		end
	end

	assign cpu_rdata_o = rdata_reg;
	assign cpu_rsel_o = rsel_reg;
	assign irq_req_n_o = irq_n_reg;

	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	// Request follows the enabled flags one cycle late
	property p_irq_merge;
		|(pending_flag_reg & mask_enable_reg) |=> !irq_req_n_o;
	endproperty
	a_irq_merge: assert property (p_irq_merge) else $error("request not raised for enabled flag");
	property p_irq_quiet;
		!(|(pending_flag_reg & mask_enable_reg)) |=> irq_req_n_o;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("request raised with no enabled flag");

	// Register reads
	property p_flag_read;
		cpu_rd_i && hit(cpu_addr_i, `IFED_ADDR_FLAGS)
			|=> cpu_rsel_o && cpu_rdata_o == $past(pending_flag_reg);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read returned wrong value");
	property p_read_no_clear;
		cpu_rd_i && hit(cpu_addr_i, `IFED_ADDR_FLAGS) && !cpu_wr_i
			|=> pending_flag_reg[5:0] == ($past(pending_flag_reg[5:0]) | $past(sticky_set));
	endproperty
	a_read_no_clear: assert property (p_read_no_clear) else $error("flag read disturbed flags");
	property p_alias_read;
		cpu_rd_i && hit(cpu_addr_i, `IFED_ADDR_CLR_ALIAS) |=> cpu_rdata_o == `IFED_ALIAS_RD_VAL;
	endproperty
	a_alias_read: assert property (p_alias_read) else $error("alias read not all ones");

	// Edge flag writes and set priority
	property p_edge_write;
		wr_flags |=> pending_flag_reg[3:0] ==
			(($past(pending_flag_reg[3:0]) & $past(cpu_wdata_i[3:0])) | $past(edge_set));
	endproperty
	a_edge_write: assert property (p_edge_write) else $error("edge flag write misbehaved");

	// Enable register and edge flag set
	property p_enable_write;
		cpu_wr_i && hit(cpu_addr_i, `IFED_ADDR_ENABLES) |=> mask_enable_reg == $past(cpu_wdata_i);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write not stored");
	property p_enable_hold;
		!(cpu_wr_i && hit(cpu_addr_i, `IFED_ADDR_ENABLES)) |=> $stable(mask_enable_reg);
	endproperty
	a_enable_hold: assert property (p_enable_hold) else $error("enable changed without write");
	property p_edge_set;
		|edge_set |=> (pending_flag_reg[3:0] & $past(edge_set)) == $past(edge_set);
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("edge lost");

	// Counter and serial flags
	property p_cnt_a_clr;
		sticky_clr[4] && !cnt_a_underflow_i |=> !pending_flag_reg[`IFED_BIT_CNTA];
	endproperty
	a_cnt_a_clr: assert property (p_cnt_a_clr) else $error("counter A flag not cleared");
	property p_cnt_b_set;
		cnt_b_underflow_i |=> pending_flag_reg[`IFED_BIT_CNTB];
	endproperty
	a_cnt_b_set: assert property (p_cnt_b_set) else $error("counter B flag not set");
	property p_rx_follow;
		1'b1 |=> rx_flag_reg == $past(|serial_status_reg_i[3:0]);
	endproperty
	a_rx_follow: assert property (p_rx_follow) else $error("receive flag mismatch");
	property p_tx_follow;
		serial_status_reg_i[7] |=> tx_flag_reg;
	endproperty
	a_tx_follow: assert property (p_tx_follow) else $error("transmit flag mismatch");

	// Counter flags: set on underflow, kept until a side-effect clear
	property p_cnt_a_set;
		cnt_a_underflow_i |=> pending_flag_reg[`IFED_BIT_CNTA];
	endproperty
	a_cnt_a_set: assert property (p_cnt_a_set) else $error("counter A flag not set");
	property p_cnt_b_clr;
		sticky_clr[5] && !cnt_b_underflow_i |=> !pending_flag_reg[`IFED_BIT_CNTB];
	endproperty
	a_cnt_b_clr: assert property (p_cnt_b_clr) else $error("counter B flag not cleared");
	property p_cnt_keep;
		!(|sticky_clr[5:4])
			|=> (pending_flag_reg[5:4] & $past(pending_flag_reg[5:4])) == $past(pending_flag_reg[5:4]);
	endproperty
	a_cnt_keep: assert property (p_cnt_keep) else $error("counter flag lost without clear");

	// Transmit flag only for empty-and-not-idle, or done
	property p_tx_empty;
		serial_status_reg_i[`IFED_SS_TX_EMPTY] && !serial_status_reg_i[`IFED_SS_TX_IDLE] |=> tx_flag_reg;
	endproperty
	a_tx_empty: assert property (p_tx_empty) else $error("transmit flag missed empty state");
	property p_tx_idle_block;
		serial_status_reg_i[`IFED_SS_TX_IDLE] && !serial_status_reg_i[`IFED_SS_TX_DONE] |=> !tx_flag_reg;
	endproperty
	a_tx_idle_block: assert property (p_tx_idle_block) else $error("transmit flag set while idle");
	property p_tx_quiet;
		!serial_status_reg_i[`IFED_SS_TX_EMPTY] && !serial_status_reg_i[`IFED_SS_TX_DONE] |=> !tx_flag_reg;
	endproperty
	a_tx_quiet: assert property (p_tx_quiet) else $error("transmit flag set with no condition");

	// Edge flags move only by a detected edge or a write-back
	property p_alias_write;
		wr_alias |=> pending_flag_reg[3:0] ==
			(($past(pending_flag_reg[3:0]) & $past(cpu_wdata_i[3:0])) | $past(edge_set));
	endproperty
	a_alias_write: assert property (p_alias_write) else $error("alias write-back misbehaved");
	property p_edge_hold;
		!(wr_flags || wr_alias)
			|=> (pending_flag_reg[3:0] & $past(pending_flag_reg[3:0])) == $past(pending_flag_reg[3:0]);
	endproperty
	a_edge_hold: assert property (p_edge_hold) else $error("edge flag lost without write");
	property p_edge_only;
		1'b1 |=> (pending_flag_reg[3:0] & ~$past(pending_flag_reg[3:0]) & ~$past(edge_set)) == 4'h0;
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("edge flag set without edge");

	// Read data stands one cycle, zero when not claimed
	property p_rdata_idle;
		!cpu_rd_i |=> cpu_rdata_o == `IFED_UNMAPPED_RD_VAL && !cpu_rsel_o;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	property p_enable_read;
		cpu_rd_i && hit(cpu_addr_i, `IFED_ADDR_ENABLES)
			|=> cpu_rsel_o && cpu_rdata_o == $past(mask_enable_reg);
	endproperty
	a_enable_read: assert property (p_enable_read) else $error("enable read returned wrong value");
	property p_unmapped_read;
		cpu_rd_i && !hit(cpu_addr_i, `IFED_ADDR_FLAGS) && !hit(cpu_addr_i, `IFED_ADDR_CLR_ALIAS)
			&& !hit(cpu_addr_i, `IFED_ADDR_ENABLES) |=> !cpu_rsel_o && cpu_rdata_o == `IFED_UNMAPPED_RD_VAL;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read claimed");

	// Main scenarios
	c_irq: cover property (!irq_req_n_o);
	c_alias_wb: cover property (cpu_rd_i && hit(cpu_addr_i, `IFED_ADDR_CLR_ALIAS) ##[1:3] wr_flags);
	c_set_vs_clr: cover property (|(edge_set & edge_clr));
	c_cnt_set_wins: cover property (cnt_a_underflow_i && sticky_clr[4]);
	c_serial_irq: cover property (rx_flag_reg && !irq_req_n_o);
endmodule : ifed_irq_ctrl

/* ifed_pin_model.sv */
// Port pin source that pulses the four edge-detect pins
`timescale 1ns/1ps
module ifed_pin_model (
	// Clock
	input wire logic ref_clk_i,
	// Pulse request
	input wire logic [1:0] pin_sel_i,
	input wire logic go_i,
	// Pins: rise pins idle low, fall pins idle high
	output logic [3:0] pins_o
);
	logic [1:0] idx;

	initial pins_o = 4'hc;

	// Leave idle, hold, return, then stay quiet before the next request
	always @(negedge ref_clk_i) begin
		if (go_i) begin
			idx = pin_sel_i;
			pins_o[idx] = ~pins_o[idx];
			repeat (3) @(negedge ref_clk_i);
			pins_o[idx] = ~pins_o[idx];
			repeat (3) @(negedge ref_clk_i);
		end
	end
endmodule : ifed_pin_model

/* ifed_irq_ctrl_bench.sv */
// Self-checking bench for the interrupt flag/enable block
`timescale 1ns/1ps
module ifed_irq_ctrl_bench;
	import ifed_pkg::*;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	ifed_addr_t addr = 16'h0000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	ifed_byte_t wdata = 8'h00;
	ifed_byte_t rdata;
	logic rsel;
	logic [3:0] pins;
	logic [1:0] sel = 2'h0;
	logic go = 1'b0;
	logic cnt_a = 1'b0;
	logic cnt_b = 1'b0;
	ifed_byte_t ss = 8'h00;
	logic irq_n;
	ifed_byte_t got;
	logic got_sel;
	int n_mismatch = 0;
	int compares = 0;
	ifed_byte_t ss_v[6] = '{8'h01, 8'h08, 8'h40, 8'h60, 8'ha0, 8'h00};
	ifed_byte_t fl_v[6] = '{8'h40, 8'h40, 8'h80, 8'h00, 8'h80, 8'h00};

	ifed_irq_ctrl u_ifed_irq_ctrl (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cpu_addr_i(addr), .cpu_rd_i(rd),
		.cpu_wr_i(wr), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata), .cpu_rsel_o(rsel),
		.edge_pin_rise_a_i(pins[0]), .edge_pin_rise_b_i(pins[1]), .edge_pin_fall_a_i(pins[2]),
		.edge_pin_fall_b_i(pins[3]), .cnt_a_underflow_i(cnt_a), .cnt_b_underflow_i(cnt_b),
		.serial_status_reg_i(ss), .irq_req_n_o(irq_n));
	ifed_pin_model u_ifed_pin_model (.ref_clk_i(ref_clk_i), .pin_sel_i(sel), .go_i(go), .pins_o(pins));

	// Clock
	initial forever #5 ref_clk_i = ~ref_clk_i;

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus_rd(input ifed_addr_t a);
		@(negedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(negedge ref_clk_i);
		rd <= 1'b0;
		got = rdata;
		got_sel = rsel;
	endtask : bus_rd

	task automatic rd_chk(input string what, input ifed_addr_t a, input ifed_byte_t exp);
		bus_rd(a);
		check(what, got, exp);
		check({what, " sel"}, {7'h00, got_sel}, {7'h00, a >= 16'h0010 && a <= 16'h0012});
	endtask : rd_chk

	task automatic bus_wr(input ifed_addr_t a, input ifed_byte_t d);
		@(negedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(negedge ref_clk_i);
		wr <= 1'b0;
	endtask : bus_wr

	task automatic edge_pulse(input logic [1:0] i);
		@(negedge ref_clk_i);
		sel <= i;
		go <= 1'b1;
		@(negedge ref_clk_i);
		go <= 1'b0;
		repeat (10) @(negedge ref_clk_i);
	endtask : edge_pulse

	task automatic uf(input int i);
		@(negedge ref_clk_i);
		cnt_a <= (i == 0);
		cnt_b <= (i == 1);
		@(negedge ref_clk_i);
		cnt_a <= 1'b0;
		cnt_b <= 1'b0;
	endtask : uf

	task automatic irq_chk(input string what, input logic exp);
		repeat (2) @(negedge ref_clk_i);
		check(what, {7'h00, irq_n}, {7'h00, exp});
	endtask : irq_chk

	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	// Watchdog
	initial begin
		#100us;
		n_mismatch++;
		final_report();
	end

	// Test sequence
	initial begin
		repeat (16) @(negedge ref_clk_i);
		arst_n_i <= 1'b1;
		rd_chk("flags rst", 16'h0011, 8'h00);
		rd_chk("enables rst", 16'h0012, 8'h00);
		check("irq idle", {7'h00, irq_n}, 8'h01);
		rd_chk("alias", 16'h0010, 8'hff);
		rd_chk("unmapped", 16'h0020, 8'h00);
		$display("test reset done");
		bus_wr(16'h0012, 8'ha5);
		rd_chk("en set", 16'h0012, 8'ha5);
		bus_wr(16'h0012, 8'h5a);
		rd_chk("en swap", 16'h0012, 8'h5a);
		bus_wr(16'h0012, 8'h00);
		$display("test enables done");
		for (int i = 0; i < 4; i++) begin
			edge_pulse(i[1:0]);
			rd_chk("edge flag", 16'h0011, 8'h0f >> (3 - i));
			rd_chk("edge reread", 16'h0011, 8'h0f >> (3 - i));
		end
		for (int i = 0; i < 4; i++) begin
			bus_rd(16'h0010);
			check("alias rmw", got, 8'hff);
			bus_wr(16'h0011, ~(8'h01 << i));
			rd_chk("edge clr", 16'h0011, (8'h0e << i) & 8'h0f);
		end
		// Rise edge lands in the very cycle of a clearing write-back
		@(negedge ref_clk_i);
		sel <= 2'h0;
		go <= 1'b1;
		@(negedge ref_clk_i);
		go <= 1'b0;
		repeat (2) @(negedge ref_clk_i);
		bus_wr(16'h0011, 8'h00);
		rd_chk("edge set wins", 16'h0011, 8'h01);
		$display("test edges done");
		for (int i = 0; i < 2; i++) begin
			uf(i);
			bus_wr(16'h0011, 8'h00);
			rd_chk("cnt flag", 16'h0011, 8'h10 << i);
			bus_rd(16'h0018 + 16'(4 * i));
			rd_chk("cnt rd clr", 16'h0011, 8'h00);
			uf(i);
			bus_wr(16'h001a + 16'(4 * i), 8'h5c);
			rd_chk("cnt wr clr", 16'h0011, 8'h00);
		end
		@(negedge ref_clk_i);
		addr <= 16'h001a;
		wr <= 1'b1;
		cnt_a <= 1'b1;
		@(negedge ref_clk_i);
		wr <= 1'b0;
		cnt_a <= 1'b0;
		rd_chk("set wins", 16'h0011, 8'h10);
		$display("test counters done");
		uf(1);
		irq_chk("irq masked", 1'b1);
		bus_wr(16'h0012, 8'h30);
		irq_chk("irq two", 1'b0);
		bus_wr(16'h001a, 8'h00);
		irq_chk("irq one left", 1'b0);
		bus_wr(16'h001e, 8'h00);
		irq_chk("irq none left", 1'b1);
		$display("test request done");
		for (int i = 0; i < 6; i++) begin
			@(negedge ref_clk_i);
			ss <= ss_v[i];
			repeat (2) @(negedge ref_clk_i);
			rd_chk("serial flag", 16'h0011, fl_v[i]);
		end
		$display("test serial done");
		bus_wr(16'h0012, 8'hff);
		ss <= 8'h01;
		irq_chk("irq serial", 1'b0);
		uf(0);
		edge_pulse(2'h3);
		rd_chk("flags pre rst", 16'h0011, 8'h58);
		// Reset in mid-run clears flags and enables
		@(negedge ref_clk_i);
		ss <= 8'h00;
		arst_n_i <= 1'b0;
		repeat (2) @(negedge ref_clk_i);
		check("irq in rst", {7'h00, irq_n}, 8'h01);
		arst_n_i <= 1'b1;
		rd_chk("flags after rst", 16'h0011, 8'h00);
		rd_chk("enables after rst", 16'h0012, 8'h00);
		irq_chk("irq after rst", 1'b1);
		$display("test reset again done");
		final_report();
	end
endmodule : ifed_irq_ctrl_bench
